// ==== hdl/sector_lock_protection.sv ====
// sector lock protection: persistent and volatile locks with command sequencer
`include "sector_lock_map.svh"
module sector_lock_protection
  import sector_lock_pkg::*;
#(
  parameter int NUM_SECT      = 256,
  parameter int NUM_SUB       = 16,
  parameter int PROG_TIME_NS  = 1000,
  parameter int ERASE_TIME_NS = 1000000
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        softReset,
  input  wire logic                        globalFreeze,
  input  wire logic                        cmdValid,
  output logic                             cmdReady,
  input  wire lock_cmd_e                   cmdOp,
  input  wire logic [$clog2(NUM_SECT)-1:0] cmdSector,
  input  wire logic [$clog2(NUM_SUB)-1:0]  cmdSub,
  input  wire logic [7:0]                  cmdData,
  output logic                             rspValid,
  output logic [7:0]                       rspData,
  output logic                             opDone,
  output logic                             cmdRefused,
  output logic                             opBusy,
  input  wire logic                        chkValid,
  input  wire logic [$clog2(NUM_SECT)-1:0] chkSector,
  input  wire logic [$clog2(NUM_SUB)-1:0]  chkSub,
  output logic                             chkAck,
  output logic                             chkAllowed
);

  // =====================================================
  // sizes and timing
  localparam int SECT_W    = $clog2(NUM_SECT);
  localparam int SUB_W     = $clog2(NUM_SUB);
  localparam int ENTRIES   = NUM_SECT + 2 * NUM_SUB;
  localparam int IDX_W     = $clog2(ENTRIES);
  localparam int PROG_RAW  = (PROG_TIME_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS;
  localparam int ERASE_RAW = (ERASE_TIME_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS;
  localparam int PROG_CYC  = (PROG_RAW < 1) ? 1 : PROG_RAW;
  localparam int ERASE_CYC = (ERASE_RAW < 1) ? 1 : ERASE_RAW;
  localparam int MAX_CYC   = (PROG_CYC > ERASE_CYC) ? PROG_CYC : ERASE_CYC;
  localparam int CNT_W     = $clog2(MAX_CYC + 1);

  // volatile register index: end sectors map to subsector slots
  function automatic logic [IDX_W-1:0] volIdx(input logic [SECT_W-1:0] s,
                                              input logic [SUB_W-1:0] u);
    logic [IDX_W-1:0] idx;
    idx = IDX_W'(s);
    if (s == '0)
      idx = IDX_W'(NUM_SECT) + IDX_W'(u);
    else if (s == SECT_W'(NUM_SECT - 1))
      idx = IDX_W'(NUM_SECT + NUM_SUB) + IDX_W'(u);
    return idx;
  endfunction

  lock_state_e                state_r;
  logic [NUM_SECT-1:0]        nvBits_r;
  logic [SECT_W-1:0]          opSector_r;
  logic                       timerStart;
  logic [CNT_W-1:0]           timerLoad;
  logic                       timerBusy;
  logic                       timerExpire;
  logic                       accept;
  logic                       plAllowed;
  logic                       vlWrEn;
  logic [`SLP_VL_FIELD_W-1:0] cmdVl;
  logic [`SLP_VL_FIELD_W-1:0] chkVl;

  // =====================================================
  // command decode
  assign cmdReady  = (state_r == ST_IDLE);
  assign accept    = cmdValid && cmdReady;
  assign plAllowed = (globalFreeze == `SLP_FREEZE_OFF);
  assign vlWrEn    = accept && cmdOp == CMD_WR_VLOCK && !cmdVl[`SLP_VL_LDOWN];
  assign timerStart = accept && plAllowed &&
                      (cmdOp == CMD_WR_PLOCK || cmdOp == CMD_ER_PLOCK);
  assign timerLoad  = (cmdOp == CMD_ER_PLOCK) ? CNT_W'(ERASE_CYC) : CNT_W'(PROG_CYC);

  lock_op_timer #(
    .CNT_W (CNT_W)
  ) i_lock_op_timer (
    .clk       (clk),
    .reset     (reset),
    .start     (timerStart),
    .loadCount (timerLoad),
    .busy      (timerBusy),
    .expire    (timerExpire)
  );

  volatile_lock_regs #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W)
  ) i_volatile_lock_regs (
    .clk       (clk),
    .reset     (reset),
    .softReset (softReset),
    .wrEn      (vlWrEn),
    .wrIdx     (volIdx(cmdSector, cmdSub)),
    .wrData    (cmdData[`SLP_VL_FIELD_W-1:0]),
    .rdIdx     (volIdx(cmdSector, cmdSub)),
    .rdData    (cmdVl),
    .chkIdx    (volIdx(chkSector, chkSub)),
    .chkData   (chkVl)
  );

  // =====================================================
  // sequencer: persistent operations hold the port until timed out
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (timerStart && cmdOp == CMD_WR_PLOCK)
            state_r <= ST_PROG;
          else if (timerStart)
            state_r <= ST_ERASE;
        end
        ST_PROG, ST_ERASE:
        begin
          if (timerExpire)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // target sector of a pending persistent program
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      opSector_r <= '0;
    else if (timerStart)
      opSector_r <= cmdSector;
  end

  // =====================================================
  // persistent bits model non-volatile cells, so reset leaves them alone
  always_ff @(posedge clk)
  begin
    if (state_r == ST_PROG && timerExpire)
      nvBits_r[opSector_r] <= `SLP_PL_LOCKED;
    else if (state_r == ST_ERASE && timerExpire)
      nvBits_r <= {NUM_SECT{`SLP_PL_UNLOCKED}};
  end

  // =====================================================
  // responses to the host
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rspValid <= 1'b0;
      rspData  <= `SLP_RSP_RESET;
    end
    else
    begin
      rspValid <= accept && (cmdOp == CMD_RD_PLOCK || cmdOp == CMD_RD_VLOCK);
      if (accept && cmdOp == CMD_RD_PLOCK)
        rspData <= {`SLP_PL_RSP_PAD, nvBits_r[cmdSector]};
      else if (accept && cmdOp == CMD_RD_VLOCK)
        rspData <= {`SLP_VL_RSV_ZERO, cmdVl};
    end
  end

  // completion and refusal pulses, and the busy level
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      opDone     <= 1'b0;
      cmdRefused <= 1'b0;
      opBusy     <= 1'b0;
    end
    else
    begin
      opDone     <= (state_r != ST_IDLE && timerExpire) || vlWrEn;
      cmdRefused <= accept && ((!plAllowed && (cmdOp == CMD_WR_PLOCK ||
                                               cmdOp == CMD_ER_PLOCK)) ||
                               (cmdOp == CMD_WR_VLOCK && cmdVl[`SLP_VL_LDOWN]) ||
                               cmdOp == CMD_NONE || cmdOp > CMD_RD_VLOCK);
      opBusy     <= timerStart || (timerBusy && !timerExpire);
    end
  end

  // =====================================================
  // program/erase permission check; a locked sector is refused
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chkAck     <= 1'b0;
      chkAllowed <= 1'b0;
    end
    else
    begin
      chkAck <= chkValid;
      if (chkValid)
        chkAllowed <= (nvBits_r[chkSector] == `SLP_PL_UNLOCKED) &&
                      !chkVl[`SLP_VL_WLOCK];
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [CNT_W:0] elapsed_r;

  // cycles since the last persistent operation was started
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      elapsed_r <= '0;
    else if (timerStart)
      elapsed_r <= '0;
    else if (elapsed_r != '1)
      elapsed_r <= elapsed_r + (CNT_W+1)'(1);
  end

  sequence s_progAccept;
    timerStart && cmdOp == CMD_WR_PLOCK;
  endsequence

  sequence s_frozenReq;
    accept && !plAllowed && (cmdOp == CMD_WR_PLOCK || cmdOp == CMD_ER_PLOCK);
  endsequence

  a_prog_locks: assert property (state_r == ST_PROG && timerExpire |=>
    nvBits_r[opSector_r] == `SLP_PL_LOCKED && opDone)
    else $error("persistent program did not lock the sector");

  a_prog_timing: assert property (state_r == ST_PROG && timerExpire |->
    elapsed_r == (CNT_W+1)'(PROG_CYC - 1))
    else $error("persistent program time wrong");

  a_erase_unlocks: assert property (state_r == ST_ERASE && timerExpire |=>
    &nvBits_r)
    else $error("persistent erase left a sector locked");

  // case equality: the cells are unknown until the first erase completes
  a_erase_atomic: assert property (state_r == ST_ERASE && !timerExpire |=>
    nvBits_r === $past(nvBits_r))
    else $error("persistent bits changed part way through erase");

  a_frozen_refuse: assert property (s_frozenReq |=>
    cmdRefused && state_r == ST_IDLE && $stable(nvBits_r))
    else $error("persistent change taken while frozen");

  a_prog_busy: assert property (s_progAccept |=> opBusy && !cmdReady [*2])
    else $error("port not held during persistent program");

  a_rd_plock: assert property (accept && cmdOp == CMD_RD_PLOCK |=>
    rspValid && rspData == {`SLP_PL_RSP_PAD, $past(nvBits_r[cmdSector])})
    else $error("persistent read returned wrong value");

  a_rd_vlock: assert property (accept && cmdOp == CMD_RD_VLOCK |=>
    rspValid && rspData[7:2] == `SLP_VL_RSV_ZERO)
    else $error("volatile read reserved bits not zero");

  a_ldown_refuse: assert property (accept && cmdOp == CMD_WR_VLOCK &&
    cmdVl[`SLP_VL_LDOWN] |=> cmdRefused && !opDone)
    else $error("write to locked-down register not refused");

  a_check_gate: assert property (chkValid && chkVl[`SLP_VL_WLOCK] |=>
    chkAck && !chkAllowed)
    else $error("write-locked sector reported as allowed");

  // a persistently locked sector is never reported as writable
  a_check_plock: assert property (chkValid &&
    nvBits_r[chkSector] == `SLP_PL_LOCKED |=> chkAck && !chkAllowed)
    else $error("persistently locked sector reported as allowed");

  // erase holds the port for the whole erase time
  a_erase_timing: assert property (state_r == ST_ERASE && timerExpire |->
    elapsed_r == (CNT_W+1)'(ERASE_CYC - 1))
    else $error("persistent erase time wrong");

  // a taken volatile write is confirmed in the next cycle
  a_vl_write_done: assert property (vlWrEn |=> opDone && !cmdRefused)
    else $error("volatile write not confirmed");

  // volatile read returns both fields of the addressed register
  a_rd_vlock_data: assert property (accept && cmdOp == CMD_RD_VLOCK |=>
    rspData[`SLP_VL_FIELD_W-1:0] == $past(cmdVl))
    else $error("volatile read returned wrong fields");

endmodule

// ==== hdl/sector_lock_map.svh ====
// register field positions and fixed values for the sector lock block
`ifndef SECTOR_LOCK_MAP_SVH
`define SECTOR_LOCK_MAP_SVH

// =====================================================
// volatile lock register fields
`define SLP_VL_WLOCK      0
`define SLP_VL_LDOWN      1
`define SLP_VL_FIELD_W    2
`define SLP_VL_RESET      2'h0
`define SLP_VL_RSV_ZERO   6'h00

// =====================================================
// persistent lock values and response padding
`define SLP_PL_LOCKED     1'b0
`define SLP_PL_UNLOCKED   1'b1
`define SLP_PL_RSP_PAD    7'h00
`define SLP_RSP_RESET     8'h00

// =====================================================
// clock and freeze encoding
`define SLP_CLK_PERIOD_NS 5
`define SLP_FREEZE_OFF    1'b1

`endif

// ==== hdl/sector_lock_pkg.sv ====
// types shared by the sector lock block
package sector_lock_pkg;

  // host commands on the lock command port
  typedef enum logic [2:0] {
    CMD_NONE     = 3'b000,
    CMD_WR_PLOCK = 3'b001,
    CMD_ER_PLOCK = 3'b010,
    CMD_RD_PLOCK = 3'b011,
    CMD_WR_VLOCK = 3'b100,
    CMD_RD_VLOCK = 3'b101
  } lock_cmd_e;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10
  } lock_state_e;

endpackage

// ==== hdl/lock_op_timer.sv ====
// down counter that times persistent lock program and erase
module lock_op_timer #(
  parameter int CNT_W = 18
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] loadCount,
  output logic                  busy,
  output logic                  expire
);

  logic [CNT_W-1:0] cnt_r;

  // =====================================================
  // count down; a start while running is not expected
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (start)
      cnt_r <= loadCount;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - CNT_W'(1);
  end

  assign busy   = (cnt_r != '0);
  assign expire = (cnt_r == CNT_W'(1));

endmodule

// ==== hdl/volatile_lock_regs.sv ====
// array of per-sector and per-subsector volatile lock registers
`include "sector_lock_map.svh"
module volatile_lock_regs #(
  parameter int ENTRIES = 288,
  parameter int IDX_W   = 9
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       softReset,
  input  wire logic                       wrEn,
  input  wire logic [IDX_W-1:0]           wrIdx,
  input  wire logic [`SLP_VL_FIELD_W-1:0] wrData,
  input  wire logic [IDX_W-1:0]           rdIdx,
  output logic      [`SLP_VL_FIELD_W-1:0] rdData,
  input  wire logic [IDX_W-1:0]           chkIdx,
  output logic      [`SLP_VL_FIELD_W-1:0] chkData
);

  logic [`SLP_VL_FIELD_W-1:0] vl_r [ENTRIES];

  // =====================================================
  // one register per entry; lock-down freezes both fields
  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_entry
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        vl_r[i] <= `SLP_VL_RESET;
      else if (softReset)
        vl_r[i] <= `SLP_VL_RESET;
      else if (wrEn && wrIdx == IDX_W'(i) && !vl_r[i][`SLP_VL_LDOWN])
        vl_r[i] <= wrData;
    end

    a_lockdown_hold: assert property (@(posedge clk) disable iff (reset)
      vl_r[i][`SLP_VL_LDOWN] && !softReset |=> vl_r[i] == $past(vl_r[i]))
      else $error("locked-down volatile register changed");

    a_soft_clear: assert property (@(posedge clk) disable iff (reset)
      softReset |=> vl_r[i] == `SLP_VL_RESET)
      else $error("volatile lock not cleared by soft reset");
  end

  // read ports for the command path and the protection check
  assign rdData  = vl_r[rdIdx];
  assign chkData = vl_r[chkIdx];

endmodule

// ==== dv/lock_cmd_host.sv ====
// host model that issues lock commands on the command port
module lock_cmd_host
  import sector_lock_pkg::*;
#(
  parameter int SW = 3
) (
  input  wire logic          clk,
  input  wire logic          cmdReady,
  input  wire logic          rspValid,
  input  wire logic [7:0]    rspData,
  input  wire logic          opDone,
  input  wire logic          cmdRefused,
  output logic               cmdValid,
  output lock_cmd_e          cmdOp,
  output logic      [SW-1:0] cmdSector,
  output logic      [3:0]    cmdSub,
  output logic      [7:0]    cmdData
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    cmdValid  = 1'b0;
    cmdOp     = CMD_NONE;
    cmdSector = '0;
    cmdSub    = 4'h0;
    cmdData   = 8'h00;
  end

  // ===========================
  // one command and its answer
  // kind 0 read data, 1 done, 2 refused, 3 none; lat in cycles after accept
  task automatic issue(input lock_cmd_e op, input logic [SW-1:0] sec,
                       input logic [3:0] sub, input logic [7:0] dat,
                       output int kind, output logic [7:0] rd, output int lat);
    logic rdy;
    rdy  = 1'b0;
    kind = 3;
    rd   = 8'h00;
    lat  = 0;
    @(posedge clk);
    #1;
    cmdValid  = 1'b1;
    cmdOp     = op;
    cmdSector = sec;
    cmdSub    = sub;
    cmdData   = dat;
    // held until an edge with ready high; ready is sampled mid-cycle to avoid races
    for (int i = 0; i < 100 && !rdy; i++)
    begin
      @(negedge clk);
      rdy = cmdReady;
      @(posedge clk);
    end
    #1;
    cmdValid = 1'b0;
    cmdOp    = CMD_NONE;
    cmdData  = ~cmdData; // released data is not left at its last value
    if (rdy)
    begin
      for (int n = 1; n < 64 && kind == 3; n++)
      begin
        @(negedge clk);
        lat = n;
        if (rspValid === 1'b1)
        begin
          kind = 0;
          rd   = rspData;
        end
        else if (opDone === 1'b1)
          kind = 1;
        else if (cmdRefused === 1'b1)
          kind = 2;
      end
    end
  endtask
endmodule

// ==== dv/tb_sector_lock_protection.sv ====
// self-checking bench for the sector lock block
module tb_sector_lock_protection
  import sector_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int NS = 8;
  localparam int PC = 10; // 50 ns program time at 5 ns
  localparam int EC = 20; // 100 ns erase time at 5 ns

  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic            softReset = 1'b0;
  logic            globalFreeze = 1'b1;
  logic            cmdValid;
  logic            cmdReady;
  lock_cmd_e       cmdOp;
  logic [2:0]      cmdSector;
  logic [3:0]      cmdSub;
  logic [7:0]      cmdData;
  logic            rspValid;
  logic [7:0]      rspData;
  logic            opDone;
  logic            cmdRefused;
  logic            opBusy;
  logic            chkValid = 1'b0;
  logic [2:0]      chkSector = 3'h0;
  logic [3:0]      chkSub = 4'h0;
  logic            chkAck;
  logic            chkAllowed;
  int              error_cnt = 0;
  int              n_compared = 0;
  int              cycles = 0;
  int              busyCyc = 0;
  int              busyMark = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  sector_lock_protection #(.NUM_SECT(NS), .NUM_SUB(16), .PROG_TIME_NS(50),
    .ERASE_TIME_NS(100)) i_sector_lock_protection (.clk(clk), .reset(reset),
    .softReset(softReset), .globalFreeze(globalFreeze), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdSector(cmdSector), .cmdSub(cmdSub),
    .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .opDone(opDone),
    .cmdRefused(cmdRefused), .opBusy(opBusy), .chkValid(chkValid),
    .chkSector(chkSector), .chkSub(chkSub), .chkAck(chkAck), .chkAllowed(chkAllowed));

  lock_cmd_host #(.SW(3)) i_lock_cmd_host (.clk(clk), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .opDone(opDone), .cmdRefused(cmdRefused),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSector(cmdSector), .cmdSub(cmdSub),
    .cmdData(cmdData));

  // ===========================
  // compares and closing
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // busy cycles, sampled mid-cycle where the registered level is settled
  always @(negedge clk)
  begin
    if (opBusy === 1'b1)
      busyCyc++;
  end

  // hang guard, well above the roughly 160 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ===========================
  // access tasks
  task automatic do_cmd(input lock_cmd_e op, input logic [2:0] sec, input logic [3:0] sub,
                        input logic [7:0] dat, input int ek, input logic [7:0] er,
                        input int el);
    int         kind;
    int         lat;
    logic [7:0] rd;
    i_lock_cmd_host.issue(op, sec, sub, dat, kind, rd, lat);
    check_count(kind, ek);
    check_count(lat, el);
    if (ek == 0)
      check_byte(rd, er);
  endtask

  task automatic rd(input lock_cmd_e op, input logic [2:0] s, input logic [3:0] u,
                    input logic [7:0] e);
    do_cmd(op, s, u, 8'h00, 0, e, 1);
  endtask

  task automatic wv(input logic [2:0] s, input logic [3:0] u, input logic [7:0] d,
                    input int k);
    do_cmd(CMD_WR_VLOCK, s, u, d, k, 8'h00, 1);
  endtask

  // permission query; answer one cycle after the taking edge
  task automatic query(input logic [2:0] s, input logic [3:0] u, input logic e);
    @(posedge clk);
    #1;
    chkValid  = 1'b1;
    chkSector = s;
    chkSub    = u;
    @(posedge clk);
    #1;
    chkValid = 1'b0;
    chkSub   = ~u;
    @(negedge clk);
    check_byte({7'h00, chkAck}, 8'h01);
    check_byte({7'h00, chkAllowed}, {7'h00, e});
  endtask

  task automatic hw_reset();
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
  endtask

  // ===========================
  // main sequence
  initial
  begin
    hw_reset();
    rd(CMD_RD_VLOCK, 3, 0, 8'h00);
    do_cmd(CMD_ER_PLOCK, 0, 0, 8'h00, 1, 8'h00, EC + 1);
    for (int s = 0; s < NS; s++)
      rd(CMD_RD_PLOCK, 3'(s), 0, 8'h01);
    query(3, 0, 1'b1);
    busyMark = busyCyc;
    do_cmd(CMD_WR_PLOCK, 2, 0, 8'h00, 1, 8'h00, PC + 1);
    check_count(busyCyc - busyMark, PC);
    rd(CMD_RD_PLOCK, 2, 0, 8'h00);
    rd(CMD_RD_PLOCK, 3, 0, 8'h01);
    query(2, 0, 1'b0);
    // frozen: persistent changes refused, bits untouched
    @(posedge clk);
    #1 globalFreeze = 1'b0;
    do_cmd(CMD_WR_PLOCK, 4, 0, 8'h00, 2, 8'h00, 1);
    do_cmd(CMD_ER_PLOCK, 0, 0, 8'h00, 2, 8'h00, 1);
    rd(CMD_RD_PLOCK, 4, 0, 8'h01);
    rd(CMD_RD_PLOCK, 2, 0, 8'h00);
    @(posedge clk);
    #1 globalFreeze = 1'b1;
    // volatile write, reserved bits dropped
    wv(5, 0, 8'hfd, 1);
    rd(CMD_RD_VLOCK, 5, 0, 8'h01);
    query(5, 0, 1'b0);
    wv(5, 0, 8'h00, 1);
    query(5, 0, 1'b1);
    wv(5, 0, 8'h03, 1);
    wv(5, 0, 8'h00, 2);
    rd(CMD_RD_VLOCK, 5, 0, 8'h03);
    query(5, 0, 1'b0);
    // end sectors per subsector
    wv(0, 3, 8'h01, 1);
    wv(7, 15, 8'h01, 1);
    rd(CMD_RD_VLOCK, 0, 3, 8'h01);
    rd(CMD_RD_VLOCK, 0, 4, 8'h00);
    query(0, 4, 1'b1);
    query(7, 15, 1'b0);
    @(posedge clk);
    #1 softReset = 1'b1;
    @(posedge clk);
    #1 softReset = 1'b0;
    rd(CMD_RD_VLOCK, 5, 0, 8'h00);
    rd(CMD_RD_VLOCK, 0, 3, 8'h00);
    rd(CMD_RD_PLOCK, 2, 0, 8'h00);
    wv(6, 0, 8'h03, 1);
    hw_reset();
    rd(CMD_RD_VLOCK, 6, 0, 8'h00);
    rd(CMD_RD_PLOCK, 2, 0, 8'h00);
    do_cmd(CMD_NONE, 1, 0, 8'h00, 2, 8'h00, 1);
    for (int c = 6; c < 8; c++)
      do_cmd(lock_cmd_e'(3'(c)), 1, 0, 8'h00, 2, 8'h00, 1);
    busyMark = busyCyc;
    do_cmd(CMD_ER_PLOCK, 0, 0, 8'h00, 1, 8'h00, EC + 1);
    check_count(busyCyc - busyMark, EC);
    rd(CMD_RD_PLOCK, 2, 0, 8'h01);
    end_sim();
  end
endmodule
